// ===== rtl/nand_status_consts.svh
// constants for the nand status and ecc block
`ifndef NAND_STATUS_CONSTS_SVH
`define NAND_STATUS_CONSTS_SVH
// opcodes
`define OPC_WREN 8'h06
`define OPC_WRDI 8'h04
`define OPC_GETF 8'h0F
`define OPC_SETF 8'h1F
`define OPC_RESET 8'hFF
`define OPC_PGRD 8'h13
`define OPC_PEXE 8'h10
`define OPC_BERS 8'hD8
// feature addresses
`define FA_STATUS 8'hC0
`define FA_CFG 8'hB0
`define CFG_ECC_BIT 4
// status bit positions
`define ST_BUSY 0
`define ST_WLATCH 1
`define ST_EFAIL 2
`define ST_PFAIL 3
`define ST_ECC_LO 4
// correction result codes
`define ECC_NONE 2'h0
`define ECC_FIXED 2'h1
`define ECC_UNFIX 2'h2
`define ECC_MAX_FIX 3'h4
// page layout
`define COL_SPARE 12'h800
`define COL_LAST 12'h83F
`define SPARE_META 2'h1
// reset command busy time
`define T_RST_NS 5000
`define CLK_NS 25
`define RST_CYC ((`T_RST_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== rtl/nand_status_pkg.sv
// types for the nand status and ecc block
`default_nettype none
package nand_status_pkg;
  typedef enum logic [4:0] {
    OP_IDLE  = 5'h01,
    OP_READ  = 5'h02,
    OP_PROG  = 5'h04,
    OP_ERASE = 5'h08,
    OP_RESET = 5'h10
  } op_state_e;
  typedef logic [15:0] parity_t;
endpackage
`default_nettype wire

// ===== rtl/ecc_stream_if.sv
// byte stream from the cache into the parity engine
`default_nettype none
interface ecc_stream_if;
  logic clear;
  logic valid;
  logic [11:0] col;
  logic [7:0] data;
  logic [63:0] parity;
  modport src (output clear, output valid, output col, output data,
               input parity);
  modport eng (input clear, input valid, input col, input data,
               output parity);
endinterface
`default_nettype wire

// ===== rtl/ecc_seg_parity.sv
// per-segment parity over the protected bytes of a page
`include "nand_status_consts.svh"
`default_nettype none
module ecc_seg_parity
  import nand_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // stream
  ecc_stream_if.eng s
);
  logic in_main;
  logic in_meta;
  logic [1:0] seg;

  function automatic parity_t crc_byte(parity_t c, logic [7:0] d);
    parity_t r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ 16'h1021) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // main bytes and the metadata field (bytes 4 to 7) of each 16-byte spare group only; the rest is unprotected
  assign in_main = s.col < `COL_SPARE;
  assign in_meta = (s.col <= `COL_LAST) && !in_main &&
                   (s.col[3:2] == `SPARE_META);
  assign seg = in_main ? s.col[10:9] : s.col[5:4];

  for (genvar g = 0; g < 4; g++) begin : g_seg
    parity_t acc_reg;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        acc_reg <= 16'hFFFF;
      end else if (s.clear) begin
        acc_reg <= 16'hFFFF;
      end else if (s.valid && (in_main || in_meta) && seg == 2'(g)) begin
        acc_reg <= crc_byte(acc_reg, s.data);
      end
    end
    assign s.parity[g*16 +: 16] = acc_reg;
  end
endmodule // ecc_seg_parity
`default_nettype wire

// ===== rtl/nand_status_ecc.sv
// status word, feature commands and internal ecc control
//////////////////////////////////////////////////////////////////////////
`include "nand_status_consts.svh"
`default_nettype none
module nand_status_ecc
  import nand_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe_n,
  // array engine requests
  output logic arr_read_req,
  output logic arr_prog_req,
  output logic arr_erase_req,
  output logic [15:0] arr_row,
  input wire logic arr_done,
  input wire logic arr_fail,
  input wire logic row_locked,
  // cache byte stream
  input wire logic cache_valid,
  input wire logic [11:0] cache_col,
  input wire logic [7:0] cache_byte,
  // parity to and from the hidden spare area
  input wire logic [63:0] stored_parity,
  output logic [63:0] prog_parity,
  input wire logic [2:0] corr_bits,
  output logic ecc_on,
  // status view
  output logic [7:0] operation_status
);
  //////////////////////////////////////////////////////////////////////////
  // link synchronisers and edges
  logic sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
  logic cs_s1_reg, cs_s2_reg;
  logic si_s1_reg, si_s2_reg;
  logic rise, fall;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      si_s1_reg <= 1'b0;
      si_s2_reg <= 1'b0;
    end else begin
      sclk_s1_reg <= sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_d_reg <= sclk_s2_reg;
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      si_s1_reg <= si;
      si_s2_reg <= si_s1_reg;
    end
  end
  assign rise = !cs_s2_reg && sclk_s2_reg && !sclk_d_reg;
  assign fall = !cs_s2_reg && !sclk_s2_reg && sclk_d_reg;

  //////////////////////////////////////////////////////////////////////////
  // byte assembly
  logic [6:0] in_shift_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_idx_reg;
  logic [7:0] cmd_reg;
  logic [7:0] faddr_reg;
  logic [15:0] row_sh_reg;
  logic byte_done;
  logic [7:0] rx_byte;

  assign byte_done = rise && (bit_cnt_reg == 3'h7);
  assign rx_byte = {in_shift_reg, si_s2_reg};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_shift_reg <= 7'h00;
      bit_cnt_reg <= 3'h0;
      byte_idx_reg <= 3'h0;
    end else if (cs_s2_reg) begin
      bit_cnt_reg <= 3'h0;
      byte_idx_reg <= 3'h0;
    end else if (rise) begin
      in_shift_reg <= rx_byte[6:0];
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done && byte_idx_reg != 3'h7) begin
        byte_idx_reg <= byte_idx_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_reg <= 8'h00;
      faddr_reg <= 8'h00;
      row_sh_reg <= 16'h0000;
    end else if (byte_done) begin
      if (byte_idx_reg == 3'h0) begin
        cmd_reg <= rx_byte;
      end
      if (byte_idx_reg == 3'h1) begin
        faddr_reg <= rx_byte;
      end
      row_sh_reg <= {row_sh_reg[7:0], rx_byte};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command decode
  op_state_e op_reg;
  logic busy;
  logic latch_reg;
  logic is_opc, addr_last;
  logic cmd_wren, cmd_wrdi, cmd_reset, cmd_setf;
  logic req_read, req_prog, req_erase;
  logic go_read, go_prog, go_erase;
  logic lock_prog, lock_erase;

  assign busy = (op_reg != OP_IDLE);
  assign is_opc = byte_done && (byte_idx_reg == 3'h0);
  assign addr_last = byte_done && (byte_idx_reg == 3'h3);
  // commands other than status poll and reset wait for ready
  assign cmd_wren = is_opc && rx_byte == `OPC_WREN && !busy;
  assign cmd_wrdi = is_opc && rx_byte == `OPC_WRDI && !busy;
  assign cmd_reset = is_opc && rx_byte == `OPC_RESET;
  assign cmd_setf = byte_done && byte_idx_reg == 3'h2 &&
                    cmd_reg == `OPC_SETF && !busy;
  assign req_read = addr_last && cmd_reg == `OPC_PGRD && !busy;
  assign req_prog = addr_last && cmd_reg == `OPC_PEXE && !busy && latch_reg;
  assign req_erase = addr_last && cmd_reg == `OPC_BERS && !busy && latch_reg;
  // a locked program or erase target never reaches the array
  assign lock_prog = req_prog && row_locked;
  assign lock_erase = req_erase && row_locked;
  assign go_read = req_read;
  assign go_prog = req_prog && !row_locked;
  assign go_erase = req_erase && !row_locked;

  //////////////////////////////////////////////////////////////////////////
  // operation sequencer
  logic por_pend_reg;
  logic [12:0] rst_cnt_reg;
  logic op_end;

  assign op_end = (op_reg == OP_RESET) ? (rst_cnt_reg == 13'h0000)
                                       : (busy && arr_done);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_reg <= OP_IDLE;
      por_pend_reg <= 1'b1;
      rst_cnt_reg <= 13'h0000;
      arr_read_req <= 1'b0;
      arr_prog_req <= 1'b0;
      arr_erase_req <= 1'b0;
      arr_row <= 16'h0000;
    end else begin
      arr_read_req <= 1'b0;
      arr_prog_req <= 1'b0;
      arr_erase_req <= 1'b0;
      if (rst_cnt_reg != 13'h0000) begin
        rst_cnt_reg <= rst_cnt_reg - 13'h0001;
      end
      case (op_reg)
        OP_IDLE: begin
          if (por_pend_reg) begin
            por_pend_reg <= 1'b0;
            op_reg <= OP_READ;
            arr_row <= 16'h0000;
            arr_read_req <= 1'b1;
          end else if (cmd_reset) begin
            op_reg <= OP_RESET;
            rst_cnt_reg <= 13'(`RST_CYC - 1);
          end else if (go_read) begin
            op_reg <= OP_READ;
            arr_row <= {row_sh_reg[7:0], rx_byte};
            arr_read_req <= 1'b1;
          end else if (go_prog) begin
            op_reg <= OP_PROG;
            arr_row <= {row_sh_reg[7:0], rx_byte};
            arr_prog_req <= 1'b1;
          end else if (go_erase) begin
            op_reg <= OP_ERASE;
            arr_row <= {row_sh_reg[7:0], rx_byte};
            arr_erase_req <= 1'b1;
          end
        end
        OP_READ, OP_PROG, OP_ERASE, OP_RESET: begin
          if (op_end) begin
            op_reg <= OP_IDLE;
          end
        end
        default: begin
          op_reg <= OP_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // parity engine
  ecc_stream_if es ();
  logic [63:0] par_diff;

  assign es.clear = go_read || go_prog || (por_pend_reg && !busy);
  assign es.valid = cache_valid && (op_reg == OP_READ || op_reg == OP_PROG);
  assign es.col = cache_col;
  assign es.data = cache_byte;
  assign par_diff = es.parity ^ stored_parity;

  ecc_seg_parity u_parity (
    .clk (clk),
    .nrst (nrst),
    .s (es)
  );

  // parity handed to the array for the hidden spare area
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_parity <= 64'h0000_0000_0000_0000;
    end else if (op_reg == OP_PROG && arr_done && ecc_on) begin
      prog_parity <= es.parity;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status flags; a set in the same cycle as a clear wins
  logic erase_fail_reg, prog_fail_reg;
  logic [1:0] ecc_res_reg;
  logic [1:0] ecc_class;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch_reg <= 1'b0;
    end else if (cmd_wren) begin
      latch_reg <= 1'b1;
    end else if (cmd_wrdi || cmd_reset || lock_prog || lock_erase) begin
      latch_reg <= 1'b0;
    end else if (op_end && (op_reg == OP_PROG || op_reg == OP_ERASE)) begin
      latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      erase_fail_reg <= 1'b0;
    end else if (lock_erase || (op_reg == OP_ERASE && arr_done && arr_fail))
    begin
      erase_fail_reg <= 1'b1;
    end else if (cmd_reset || go_erase) begin
      erase_fail_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_fail_reg <= 1'b0;
    end else if (lock_prog || (op_reg == OP_PROG && arr_done && arr_fail))
    begin
      prog_fail_reg <= 1'b1;
    end else if (cmd_reset || go_prog) begin
      prog_fail_reg <= 1'b0;
    end
  end

  // errors past four bits cannot be repaired and are only reported
  always_comb begin
    if (par_diff == 64'h0000_0000_0000_0000) begin
      ecc_class = `ECC_NONE;
    end else if (corr_bits != 3'h0 && corr_bits <= `ECC_MAX_FIX) begin
      ecc_class = `ECC_FIXED;
    end else begin
      ecc_class = `ECC_UNFIX;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ecc_res_reg <= `ECC_NONE;
    end else if (op_reg == OP_READ && arr_done && ecc_on) begin
      ecc_res_reg <= ecc_class;
    end else if (cmd_reset || go_read) begin
      ecc_res_reg <= `ECC_NONE;
    end
  end

  // correction switch; on from power-up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ecc_on <= 1'b1;
    end else if (cmd_setf && faddr_reg == `FA_CFG) begin
      ecc_on <= rx_byte[`CFG_ECC_BIT];
    end
  end

  assign operation_status = {2'h0, ecc_res_reg, prog_fail_reg,
                             erase_fail_reg, latch_reg,
                             busy};

  //////////////////////////////////////////////////////////////////////////
  // get-feature readout
  logic out_en_reg;
  logic [2:0] out_cnt_reg;
  logic [7:0] out_shift_reg;
  logic [7:0] feat_val;

  always_comb begin
    case (faddr_reg)
      `FA_STATUS: feat_val = operation_status;
      `FA_CFG: feat_val = 8'(ecc_on) << `CFG_ECC_BIT;
      default: feat_val = 8'h00;
    endcase
  end

  // byte reloaded at each boundary so polling sees fresh status
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_en_reg <= 1'b0;
      out_cnt_reg <= 3'h0;
      out_shift_reg <= 8'h00;
      so <= 1'b0;
    end else if (cs_s2_reg) begin
      out_en_reg <= 1'b0;
      out_cnt_reg <= 3'h0;
    end else if (byte_done && byte_idx_reg == 3'h1 &&
                 cmd_reg == `OPC_GETF) begin
      out_en_reg <= 1'b1;
    end else if (fall && out_en_reg) begin
      out_cnt_reg <= out_cnt_reg + 3'h1;
      if (out_cnt_reg == 3'h0) begin
        so <= feat_val[7];
        out_shift_reg <= {feat_val[6:0], 1'b0};
      end else begin
        so <= out_shift_reg[7];
        out_shift_reg <= {out_shift_reg[6:0], 1'b0};
      end
    end
  end
  assign so_oe_n = !out_en_reg;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_read_done;
    (op_reg == OP_READ) ##0 arr_done;
  endsequence
  sequence s_idle_req;
    !busy ##0 latch_reg;
  endsequence

  AST_BUSY_ON_READ: assert property (
    go_read |=> operation_status[`ST_BUSY] [*2])
    else $error("busy not shown during read");
  AST_WRDI_CLEARS: assert property (
    cmd_wrdi |=> !operation_status[`ST_WLATCH])
    else $error("write latch survived write disable");
  AST_NO_PROG_WO_LATCH: assert property (
    (addr_last && cmd_reg == `OPC_PEXE && !latch_reg) |=> !arr_prog_req)
    else $error("program started without write latch");
  AST_ERS_CLR: assert property (
    go_erase |=> !operation_status[`ST_EFAIL] && arr_erase_req)
    else $error("erase fail not cleared at erase start");
  AST_PGM_CLR: assert property (
    go_prog |=> !operation_status[`ST_PFAIL])
    else $error("program fail not cleared at program start");
  AST_ECC_CLR: assert property (
    go_read |=> operation_status[5:4] == `ECC_NONE)
    else $error("result not cleared at read start");
  AST_LOCK_ERS: assert property (
    (s_idle_req ##0 lock_erase) |=> operation_status[3:0] == 4'h4)
    else $error("locked erase status wrong");
  AST_LOCK_PGM: assert property (
    (s_idle_req ##0 lock_prog) |=> operation_status[3:0] == 4'h8)
    else $error("locked program status wrong");
  AST_RSV_ZERO: assert property (
    operation_status[7:6] == 2'h0)
    else $error("reserved status bits set");
  AST_ECC_OFF: assert property (
    (s_read_done ##0 !ecc_on) |=> operation_status[5:4] == `ECC_NONE)
    else $error("result updated while correction off");
  AST_READ_RESULT: assert property (
    (s_read_done ##0 ecc_on) |=> operation_status[5:4] == $past(ecc_class)
      ##1 !operation_status[`ST_BUSY])
    else $error("read result not posted");
endmodule // nand_status_ecc
`default_nettype wire

// ===== bench/spi_host_model.sv
// serial link host model that issues flash commands
`default_nettype none
module spi_host_model #(
  parameter int HALF = 4
) (
  // clock
  input wire logic clk,
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // mode 0: clock idles low and stands still outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // msb first; rx holds the last eight bits seen on so
  task automatic xfer(input int nb, input logic [31:0] tx,
                      output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clk) cs_n = 1'b0;
    for (int i = 0; i < nb * 8; i++) begin
      si = tx[31-i];
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      repeat (HALF) @(negedge clk);
      // sampled late in the high phase: so moves only after a fall
      // an undriven so reads inverted so a missing enable is caught
      rx = {rx[6:0], so_oe_n ? ~so : so};
      sclk = 1'b0;
    end
    // released data line toggles so no stale value passes for valid
    si = ~si;
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    repeat (4 * HALF) @(negedge clk);
  endtask
endmodule // spi_host_model
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the status and ecc block
`include "nand_status_consts.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import nand_status_pkg::*;
  logic clk = 1'b0, nrst, sclk, cs_n, si, so, so_oe_n;
  logic rd_req, pg_req, er_req, arr_done, arr_fail, row_locked;
  logic [15:0] arr_row;
  logic cache_valid, ecc_on;
  logic [11:0] cache_col;
  logic [7:0] cache_byte, operation_status, rx;
  logic [63:0] stored_parity, prog_parity;
  logic [2:0] corr_bits;
  logic [7:0] nr = 8'h00, np = 8'h00, ne = 8'h00;
  int failures = 0, tests_run = 0, cyc = 0;
  logic [63:0] sp_t [3] = '{64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 64'h0};
  logic [2:0] cb_t [3] = '{3'h0, 3'h4, 3'h5};
  logic [7:0] ex_t [3] = '{8'h00, 8'h10, 8'h20};
  logic [15:0] p0;
  always #12.5 clk = ~clk;
  nand_status_ecc dut_u (.clk(clk), .nrst(nrst), .sclk(sclk),
    .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
    .arr_read_req(rd_req), .arr_prog_req(pg_req),
    .arr_erase_req(er_req), .arr_row(arr_row), .arr_done(arr_done),
    .arr_fail(arr_fail), .row_locked(row_locked),
    .cache_valid(cache_valid), .cache_col(cache_col),
    .cache_byte(cache_byte), .stored_parity(stored_parity),
    .prog_parity(prog_parity), .corr_bits(corr_bits),
    .ecc_on(ecc_on), .operation_status(operation_status));
  spi_host_model #(.HALF(4)) host_u (.clk(clk), .sclk(sclk),
    .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));
  always @(posedge clk) begin
    nr <= nr + {7'h00, rd_req};
    np <= np + {7'h00, pg_req};
    ne <= ne + {7'h00, er_req};
    cyc <= cyc + 1;
    // about 5200 cycles are needed; a hang ends the run here
    if (cyc == 60000) begin
      failures++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task complete_run;
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmd(input int nb, input logic [31:0] tx);
    host_u.xfer(nb, tx, rx);
  endtask
  task automatic gs(input logic [7:0] fa, input logic [7:0] e);
    host_u.xfer(3, {8'h0F, fa, 16'h0000}, rx);
    chk("feature", e, rx);
  endtask
  task automatic st(input logic [7:0] e);
    @(negedge clk);
    chk("status", e, operation_status);
  endtask
  // array engine reply; status settles the cycle after done
  task automatic fin(input logic f, input logic [63:0] sp,
                     input logic [2:0] cb);
    @(negedge clk);
    arr_done = 1'b1;
    arr_fail = f;
    stored_parity = sp;
    corr_bits = cb;
    @(negedge clk);
    arr_done = 1'b0;
    arr_fail = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic put(input logic [11:0] c, input logic [7:0] d);
    @(negedge clk);
    cache_valid = 1'b1;
    cache_col = c;
    cache_byte = d;
    @(negedge clk);
    cache_valid = 1'b0;
  endtask
  function automatic logic [15:0] crc(input logic [15:0] c,
                                      input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = (c << 1) ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  ////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    {arr_done, arr_fail, row_locked, cache_valid} = 4'h0;
    cache_col = 12'h000;
    cache_byte = 8'h00;
    stored_parity = 64'h0;
    corr_bits = 3'h0;
    repeat (5) @(negedge clk);
    chk("reset status", 8'h00, operation_status);
    chk("ecc enable", 1'b1, ecc_on);
    chk("so enable", 1'b1, so_oe_n);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    chk("reads", 8'h01, nr);
    chk("row", 16'h0000, arr_row);
    gs(8'hC0, 8'h01);
    fin(1'b0, 64'h0, 3'h3);
    gs(8'hC0, 8'h10);
    for (int k = 0; k < 3; k++) begin
      cmd(4, 32'h1300_1234);
      chk("row", 16'h1234, arr_row);
      st(8'h01);
      fin(1'b0, sp_t[k], cb_t[k]);
      st(ex_t[k]);
    end
    chk("reads", 8'h04, nr);
    cmd(1, 32'h0600_0000);
    st(8'h22);
    cmd(1, 32'h0400_0000);
    st(8'h20);
    cmd(4, 32'h1000_0005);
    chk("programs", 8'h00, np);
    cmd(1, 32'h0600_0000);
    row_locked = 1'b1;
    cmd(4, 32'hD800_0007);
    chk("erases", 8'h00, ne);
    st(8'h24);
    row_locked = 1'b0;
    cmd(1, 32'h0600_0000);
    cmd(4, 32'hD800_0007);
    chk("row", 16'h0007, arr_row);
    chk("erases", 8'h01, ne);
    st(8'h23);
    fin(1'b1, 64'h0, 3'h0);
    st(8'h24);
    cmd(1, 32'hFF00_0000);
    st(8'h01);
    repeat (`RST_CYC + 4) @(negedge clk);
    st(8'h00);
    cmd(1, 32'h0600_0000);
    row_locked = 1'b1;
    cmd(4, 32'h1000_0009);
    st(8'h08);
    row_locked = 1'b0;
    cmd(1, 32'h0600_0000);
    cmd(4, 32'h1000_0009);
    st(8'h03);
    // main segment and its metadata go in one program
    put(12'h000, 8'hA5);
    put(12'h804, 8'h3C);
    put(12'h200, 8'h5A);
    put(12'h808, 8'h77);
    fin(1'b0, 64'h0, 3'h0);
    p0 = crc(crc(16'hFFFF, 8'hA5), 8'h3C);
    chk("parity", {32'hFFFF_FFFF, crc(16'hFFFF, 8'h5A), p0},
        prog_parity);
    st(8'h00);
    cmd(1, 32'h0600_0000);
    cmd(4, 32'h1000_000A);
    fin(1'b1, 64'h0, 3'h0);
    chk("programs", 8'h02, np);
    gs(8'hC0, 8'h08);
    cmd(3, 32'h1FB0_0000);
    chk("ecc enable", 1'b0, ecc_on);
    gs(8'hB0, 8'h00);
    // result field is not judged while correction is off
    cmd(4, 32'h1300_0001);
    fin(1'b0, 64'h0, 3'h5);
    chk("status low", 4'h8, operation_status[3:0]);
    cmd(3, 32'h1FB0_1000);
    chk("ecc enable", 1'b1, ecc_on);
    gs(8'hB0, 8'h10);
    complete_run;
  end
endmodule // testbench
`default_nettype wire
